// ### otp_mode_pkg.sv
package otp_mode_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [31:0] otp_ctrl_mode_addr = 32'h4000_8000;
  localparam logic [31:0] otp_ctrl_mode_rst  = 32'h0000_0000;
  localparam int          source_mux_pos     = 28;
  localparam int          fast_pos           = 8;
  localparam int          port_sel_pos       = 7;
  localparam int          two_cycle_pos      = 6;
  localparam int          flush_pos          = 5;
  localparam int          dma_use_pos        = 4;
  localparam int          mode_pos           = 0;

  // ---------------------------------------------------------------
  // encodings
  // ---------------------------------------------------------------
  localparam logic [1:0]  mux_bandgap        = 2'h0;
  localparam logic [1:0]  mux_rssi_rfio      = 2'h1;
  localparam logic [1:0]  mux_lna            = 2'h2;
  localparam logic [1:0]  mux_vco            = 2'h3;
  localparam logic [2:0]  code_standby       = 3'h0;
  localparam logic [2:0]  code_manual_read   = 3'h1;
  localparam logic [2:0]  code_manual_prog   = 3'h2;
  localparam logic [2:0]  code_auto_read     = 3'h3;
  localparam logic [2:0]  code_auto_prog     = 3'h4;
  localparam int          word_count_width   = 16;
  localparam logic [15:0] single_word_count  = 16'h0001;

  typedef enum logic [5:0] {
    st_standby     = 6'h01,
    st_manual_read = 6'h02,
    st_manual_prog = 6'h04,
    st_auto_read   = 6'h08,
    st_auto_prog   = 6'h10,
    st_test        = 6'h20
  } op_state_type;

endpackage : otp_mode_pkg

// ### prg_word_mux.sv
module prg_word_mux
  import otp_mode_pkg::*;
(
  input  wire logic [1:0]  source_mux,
  input  wire logic [15:0] bandgap_trim_register,
  input  wire logic [15:0] rssi_compensation_register,
  input  wire logic [7:0]  rf_io_control_register,
  input  wire logic [4:0]  lna_control_third,
  input  wire logic [11:0] lna_control_second,
  input  wire logic [11:0] lna_control_first,
  input  wire logic [3:0]  vco_control_register,
  output logic      [31:0] word
);

  // ---------------------------------------------------------------
  // program-word source selection
  // ---------------------------------------------------------------
  always_comb begin
    case (source_mux)
      mux_bandgap:   word = {16'h0000, bandgap_trim_register};
      mux_rssi_rfio: word = {rssi_compensation_register, 8'h00,
                             rf_io_control_register};
      mux_lna:       word = {3'h0, lna_control_third,
                             lna_control_second,
                             lna_control_first};
      mux_vco:       word = {28'h000_0000, vco_control_register};
      default:       word = 32'h0000_0000;
    endcase
  end

endmodule : prg_word_mux

// ### read_pacer.sv
module read_pacer
  import otp_mode_pkg::*;
(
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic active,
  input  wire logic two_cycle,
  output logic      fetch
);

  typedef struct packed {
    logic phase;
    logic fetch;
  } pacer_type;

  pacer_type s_r;
  pacer_type s_nxt;

  // ---------------------------------------------------------------
  // one fetch per cycle, or one every second cycle
  // ---------------------------------------------------------------
  always_comb begin
    s_nxt       = s_r;
    s_nxt.fetch = active & (~two_cycle | ~s_r.phase);
    s_nxt.phase = active & two_cycle & ~s_r.phase;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign fetch = s_r.fetch;

endmodule : read_pacer

// ### otp_mode_ctrl.sv
module otp_mode_ctrl
  import otp_mode_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  // system bus access to the mode register
  input  wire logic        sys_wr,
  input  wire logic        sys_rd,
  input  wire logic [31:0] sys_addr,
  input  wire logic [31:0] sys_wdata,
  output logic      [31:0] sys_rdata,
  // serial interface write of the mode register
  input  wire logic        ser_wr,
  input  wire logic [31:0] ser_wdata,
  // trim register sources and word count
  input  wire logic [15:0] bandgap_trim_register,
  input  wire logic [15:0] rssi_compensation_register,
  input  wire logic [7:0]  rf_io_control_register,
  input  wire logic [4:0]  lna_control_third,
  input  wire logic [11:0] lna_control_second,
  input  wire logic [11:0] lna_control_first,
  input  wire logic [3:0]  vco_control_register,
  input  wire logic [15:0] word_count_setting,
  // controller side
  output logic      [31:0] program_word,
  output logic             fast_program_timing,
  output logic             fifo_flush,
  output logic             dma_enable,
  output logic             fifo_program_source,
  output logic             single_word_program,
  output logic      [15:0] program_word_total,
  output logic             read_fetch,
  output logic             standby_mode,
  output logic             manual_read_mode,
  output logic             manual_program_mode,
  output logic             automatic_read_mode,
  output logic             automatic_program_mode,
  output logic             test_mode,
  output logic             mode_sequence_error
);

  typedef struct packed {
    logic [1:0]   source_mux;
    logic         fast;
    logic         port_sel;
    logic         two_cycle;
    logic         dma_use;
    logic [2:0]   mode_code;
    op_state_type op;
    logic         flush;
    logic [31:0]  prg_word;
    logic [31:0]  rdata;
    logic         dma_en;
    logic         fifo_src;
    logic         single;
    logic [15:0]  total;
    logic         seq_err;
  } ctrl_type;

  ctrl_type    s_r;
  ctrl_type    s_nxt;
  logic [31:0] mux_word;
  logic [31:0] wr_data;
  logic        sys_hit_wr;
  logic        sys_hit_rd;
  logic        any_wr;
  logic        read_active;

  // ---------------------------------------------------------------
  // submodules
  // ---------------------------------------------------------------
  prg_word_mux u_mux (
    .source_mux                 (s_nxt.source_mux),
    .bandgap_trim_register      (bandgap_trim_register),
    .rssi_compensation_register (rssi_compensation_register),
    .rf_io_control_register     (rf_io_control_register),
    .lna_control_third          (lna_control_third),
    .lna_control_second         (lna_control_second),
    .lna_control_first          (lna_control_first),
    .vco_control_register       (vco_control_register),
    .word                       (mux_word)
  );

  assign read_active = s_r.op[1] | s_r.op[3];

  read_pacer u_pacer (
    .clock     (clock),
    .rst       (rst),
    .active    (read_active),
    .two_cycle (s_r.two_cycle),
    .fetch     (read_fetch)
  );

  // ---------------------------------------------------------------
  // register access
  // ---------------------------------------------------------------
  assign sys_hit_wr = sys_wr & (sys_addr == otp_ctrl_mode_addr);
  assign sys_hit_rd = sys_rd & (sys_addr == otp_ctrl_mode_addr);
  assign any_wr     = sys_hit_wr | ser_wr;
  assign wr_data    = sys_hit_wr ? sys_wdata : ser_wdata;

  always_comb begin
    s_nxt       = s_r;
    s_nxt.flush = 1'b0;
    s_nxt.rdata = 32'h0000_0000;
    if (any_wr) begin
      s_nxt.source_mux = wr_data[source_mux_pos +: 2];
      s_nxt.fast       = wr_data[fast_pos];
      s_nxt.port_sel   = wr_data[port_sel_pos];
      s_nxt.two_cycle  = wr_data[two_cycle_pos];
      s_nxt.mode_code  = wr_data[mode_pos +: 3];
      s_nxt.flush      = wr_data[flush_pos];
      // serial writes cannot enable bus mastering
      s_nxt.dma_use    = sys_hit_wr & wr_data[dma_use_pos];
      // flag leaving one active mode straight for another
      s_nxt.seq_err    = (s_r.mode_code != code_standby) &&
                         (s_nxt.mode_code != code_standby) &&
                         (s_nxt.mode_code != s_r.mode_code);
    end
    if (sys_hit_rd) begin
      // unnamed bits and the flush bit read as zero
      s_nxt.rdata[source_mux_pos +: 2] = s_r.source_mux;
      s_nxt.rdata[fast_pos]            = s_r.fast;
      s_nxt.rdata[port_sel_pos]        = s_r.port_sel;
      s_nxt.rdata[two_cycle_pos]       = s_r.two_cycle;
      s_nxt.rdata[dma_use_pos]         = s_r.dma_use;
      s_nxt.rdata[mode_pos +: 3]       = s_r.mode_code;
    end
    case (s_nxt.mode_code)
      code_standby:     s_nxt.op = st_standby;
      code_manual_read: s_nxt.op = st_manual_read;
      code_manual_prog: s_nxt.op = st_manual_prog;
      code_auto_read:   s_nxt.op = st_auto_read;
      code_auto_prog:   s_nxt.op = st_auto_prog;
      default:          s_nxt.op = st_test;
    endcase
    // data path choice of automatic programming
    s_nxt.fifo_src = (s_nxt.op == st_auto_prog) & ~s_nxt.port_sel;
    s_nxt.single   = (s_nxt.op == st_auto_prog) & s_nxt.port_sel;
    s_nxt.total    = s_nxt.single ? single_word_count
                                  : word_count_setting;
    // bus mastering only for automatic read and for automatic programming fed from the fifo
    s_nxt.dma_en   = s_nxt.dma_use & ~s_nxt.single &
                     ((s_nxt.op == st_auto_read) |
                      (s_nxt.op == st_auto_prog));
    s_nxt.prg_word = mux_word;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_r          <= '0;
      s_r.op       <= st_standby;
    end else begin
      s_r          <= s_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign sys_rdata              = s_r.rdata;
  assign program_word           = s_r.prg_word;
  assign fast_program_timing    = s_r.fast;
  assign fifo_flush             = s_r.flush;
  assign dma_enable             = s_r.dma_en;
  assign fifo_program_source    = s_r.fifo_src;
  assign single_word_program    = s_r.single;
  assign program_word_total     = s_r.total;
  assign standby_mode           = s_r.op[0];
  assign manual_read_mode       = s_r.op[1];
  assign manual_program_mode    = s_r.op[2];
  assign automatic_read_mode    = s_r.op[3];
  assign automatic_program_mode = s_r.op[4];
  assign test_mode              = s_r.op[5];
  assign mode_sequence_error    = s_r.seq_err;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  property p_word_bandgap;
    (!$past(rst) && s_r.source_mux == mux_bandgap) |->
      program_word == {16'h0000, $past(bandgap_trim_register)};
  endproperty
  a_word_bandgap: assert property (p_word_bandgap)
    else $error("bandgap program word wrong");

  property p_word_rssi;
    (!$past(rst) && s_r.source_mux == mux_rssi_rfio) |->
      program_word == {$past(rssi_compensation_register), 8'h00,
                       $past(rf_io_control_register)};
  endproperty
  a_word_rssi: assert property (p_word_rssi)
    else $error("rssi program word wrong");

  property p_word_lna;
    (!$past(rst) && s_r.source_mux == mux_lna) |->
      program_word == {3'h0, $past(lna_control_third),
                       $past(lna_control_second),
                       $past(lna_control_first)};
  endproperty
  a_word_lna: assert property (p_word_lna)
    else $error("lna program word wrong");

  property p_word_vco;
    (!$past(rst) && s_r.source_mux == mux_vco) |->
      program_word == {28'h000_0000, $past(vco_control_register)};
  endproperty
  a_word_vco: assert property (p_word_vco)
    else $error("vco program word wrong");

  property p_fast;
    sys_hit_wr |=> fast_program_timing == $past(sys_wdata[fast_pos]);
  endproperty
  a_fast: assert property (p_fast)
    else $error("fast timing not taken from write");

  property p_fifo_count;
    fifo_program_source |->
      !single_word_program &&
      program_word_total == $past(word_count_setting);
  endproperty
  a_fifo_count: assert property (p_fifo_count)
    else $error("fifo programming count wrong");

  property p_single;
    (automatic_program_mode && s_r.port_sel) |->
      single_word_program && !fifo_program_source && !dma_enable &&
      program_word_total == single_word_count;
  endproperty
  a_single: assert property (p_single)
    else $error("single word programming not isolated");

  property p_pace_two;
    (read_fetch && s_r.two_cycle && read_active) ##1
      (s_r.two_cycle && read_active) |-> !read_fetch;
  endproperty
  a_pace_two: assert property (p_pace_two)
    else $error("two-cycle read fetched back to back");

  property p_pace_one;
    (!s_r.two_cycle && read_active) |=> read_fetch;
  endproperty
  a_pace_one: assert property (p_pace_one)
    else $error("single-cycle read missed a fetch");

  property p_flush;
    (any_wr && wr_data[flush_pos]) |=> fifo_flush ##1
      (!fifo_flush || $past(any_wr));
  endproperty
  a_flush: assert property (p_flush)
    else $error("flush pulse not one cycle");

  property p_serial_dma;
    (ser_wr && !sys_hit_wr) |=> !s_r.dma_use && !dma_enable;
  endproperty
  a_serial_dma: assert property (p_serial_dma)
    else $error("serial write left dma use set");

  property p_dma_read;
    (automatic_read_mode && s_r.dma_use) |-> dma_enable;
  endproperty
  a_dma_read: assert property (p_dma_read)
    else $error("dma not enabled in automatic read");

  property p_decode;
    (sys_hit_wr && sys_wdata[2:0] == code_auto_read) |=>
      automatic_read_mode && !standby_mode;
  endproperty
  a_decode: assert property (p_decode)
    else $error("automatic read code not decoded");

  property p_rdata;
    sys_hit_rd |=> (sys_rdata & 32'hcfff_fe28) == 32'h0000_0000;
  endproperty
  a_rdata: assert property (p_rdata)
    else $error("reserved bits read nonzero");

  property p_seq_err;
    (any_wr && s_r.mode_code != code_standby &&
     wr_data[2:0] != code_standby && wr_data[2:0] != s_r.mode_code)
      |=> mode_sequence_error;
  endproperty
  a_seq_err: assert property (p_seq_err)
    else $error("direct mode change not flagged");

  property p_dma_prog;
    (automatic_program_mode && !s_r.port_sel && s_r.dma_use) |->
      dma_enable && fifo_program_source;
  endproperty
  a_dma_prog: assert property (p_dma_prog)
    else $error("dma not enabled in fifo programming");

  property p_standby_idle;
    standby_mode |->
      !dma_enable && !fifo_program_source && !single_word_program;
  endproperty
  a_standby_idle: assert property (p_standby_idle)
    else $error("standby left a data path active");

  c_flush:  cover property (fifo_flush);
  c_dma:    cover property (automatic_read_mode && dma_enable);
  c_single: cover property (single_word_program);
  c_pace:   cover property (read_fetch && s_r.two_cycle);
  c_seq:    cover property (mode_sequence_error);

endmodule : otp_mode_ctrl

// ### otp_macrocell_model.sv
module otp_macrocell_model (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       clear,
  input  wire logic       read_fetch,
  input  wire logic       fifo_flush,
  output logic      [7:0] fetch_count,
  output logic      [7:0] flush_count
);
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // macrocell side: one 16-bit word per fetch, fifo emptied per pulse
  // ---------------------------------------------------------------
  always @(posedge clock) begin
    if (rst || clear) begin
      fetch_count <= 8'h00;
    end else if (read_fetch) begin
      fetch_count <= fetch_count + 8'h01;
    end
    if (rst) begin
      flush_count <= 8'h00;
    end else if (fifo_flush) begin
      flush_count <= flush_count + 8'h01;
    end
  end

endmodule : otp_macrocell_model

// ### otp_mode_ctrl_tb.sv
module otp_mode_ctrl_tb
  import otp_mode_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [31:0] ma = otp_ctrl_mode_addr;

  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        sys_wr = 1'b0;
  logic        sys_rd = 1'b0;
  logic [31:0] sys_addr = 32'h0;
  logic [31:0] sys_wdata = 32'h0;
  logic [31:0] sys_rdata;
  logic        ser_wr = 1'b0;
  logic [31:0] ser_wdata = 32'h0;
  logic [15:0] bg = 16'ha5c3;
  logic [15:0] rssi = 16'h9e17;
  logic [7:0]  rfio = 8'h6b;
  logic [4:0]  lna3 = 5'h15;
  logic [11:0] lna2 = 12'hc3a;
  logic [11:0] lna1 = 12'h5d2;
  logic [3:0]  vco = 4'hb;
  logic [15:0] wcount = 16'h0123;
  logic [31:0] pword;
  logic [15:0] total;
  logic        fast, flush, dma, fsrc, single, fetch, seq_err;
  logic [5:0]  modes;
  logic        clear = 1'b0;
  logic [7:0]  fetch_count, flush_count;
  logic [31:0] d;
  int          n_mismatch = 0;
  int          tests_run = 0;

  always #20 clock = ~clock;

  otp_mode_ctrl u_dut (
    .clock(clock), .rst(rst), .sys_wr(sys_wr), .sys_rd(sys_rd),
    .sys_addr(sys_addr), .sys_wdata(sys_wdata), .sys_rdata(sys_rdata),
    .ser_wr(ser_wr), .ser_wdata(ser_wdata),
    .bandgap_trim_register(bg), .rssi_compensation_register(rssi),
    .rf_io_control_register(rfio), .lna_control_third(lna3),
    .lna_control_second(lna2), .lna_control_first(lna1),
    .vco_control_register(vco), .word_count_setting(wcount),
    .program_word(pword), .fast_program_timing(fast),
    .fifo_flush(flush), .dma_enable(dma), .fifo_program_source(fsrc),
    .single_word_program(single), .program_word_total(total),
    .read_fetch(fetch), .standby_mode(modes[5]),
    .manual_read_mode(modes[4]), .manual_program_mode(modes[3]),
    .automatic_read_mode(modes[2]), .automatic_program_mode(modes[1]),
    .test_mode(modes[0]), .mode_sequence_error(seq_err));

  otp_macrocell_model u_cells (
    .clock(clock), .rst(rst), .clear(clear), .read_fetch(fetch),
    .fifo_flush(flush), .fetch_count(fetch_count),
    .flush_count(flush_count));

  // ---------------------------------------------------------------
  // access and compare tasks
  // ---------------------------------------------------------------
  task automatic reg_write(input logic [31:0] a, input logic [31:0] v);
    @(negedge clock);
    sys_wr = 1'b1;
    sys_addr = a;
    sys_wdata = v;
    @(negedge clock);
    sys_wr = 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [31:0] a, output logic [31:0] v);
    @(negedge clock);
    sys_rd = 1'b1;
    sys_addr = a;
    @(negedge clock);
    sys_rd = 1'b0;
    v = sys_rdata;
  endtask : reg_read

  task automatic ser_write(input logic [31:0] v);
    @(negedge clock);
    ser_wr = 1'b1;
    ser_wdata = v;
    @(negedge clock);
    ser_wr = 1'b0;
  endtask : ser_write

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : check_word

  task automatic check_mode(input logic [2:0] c);
    check_word({26'h0, modes}, (c > 3'h4) ? 32'h1 : (32'h20 >> c));
  endtask : check_mode

  task automatic check_fetches(input logic [7:0] exp);
    @(negedge clock);
    clear = 1'b1;
    @(negedge clock);
    clear = 1'b0;
    repeat (8) @(negedge clock);
    check_word({24'h0, fetch_count}, {24'h0, exp});
  endtask : check_fetches

  function automatic logic [31:0] mux_exp(input logic [1:0] s);
    case (s)
      2'h0: return {16'h0000, bg};
      2'h1: return {rssi, 8'h00, rfio};
      2'h2: return {3'h0, lna3, lna2, lna1};
      default: return {28'h0000000, vco};
    endcase
  endfunction : mux_exp

  task automatic print_verdict;
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict

  initial begin
    #(5000 * 40);
    n_mismatch++;
    print_verdict();
  end

  // ---------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clock);
    @(negedge clock);
    rst = 1'b0;
    reg_read(ma, d);
    check_word(d, 32'h0);
    check_mode(3'h0);
    reg_write(ma, 32'hffff_ffff);
    reg_read(ma, d);
    check_word(d, 32'h3000_01d7);
    check_mode(3'h7);
    check_word({31'h0, fast}, 32'h1);
    check_word({24'h0, flush_count}, 32'h1);
    reg_write(ma, 32'h0);
    check_word({31'h0, fast}, 32'h0);
    for (int s = 0; s < 4; s++) begin
      reg_write(ma, {2'h0, s[1:0], 28'h0});
      @(negedge clock);
      check_word(pword, mux_exp(s[1:0]));
    end
    reg_write(ma, 32'h14);
    check_word({29'h0, dma, fsrc, single}, 32'h6);
    check_word({16'h0, total}, {16'h0, wcount});
    reg_write(ma, 32'h0);
    reg_write(ma, 32'h94);
    check_word({29'h0, dma, fsrc, single}, 32'h1);
    check_word({16'h0, total}, 32'h1);
    reg_write(ma, 32'h0);
    reg_write(ma, 32'h13);
    check_word({31'h0, dma}, 32'h1);
    reg_write(ma, 32'h0);
    ser_write(32'h13);
    check_word({31'h0, dma}, 32'h0);
    reg_read(ma, d);
    check_word(d, 32'h3);
    check_fetches(8'h08);
    reg_write(ma, 32'h0);
    check_fetches(8'h00);
    reg_write(ma, 32'h43);
    check_word({31'h0, dma}, 32'h0);
    check_fetches(8'h04);
    for (int c = 0; c < 5; c++) begin
      reg_write(ma, 32'h0);
      reg_write(ma, {29'h0, c[2:0]});
      check_mode(c[2:0]);
    end
    reg_write(ma, 32'h0);
    reg_write(ma + 32'h4, 32'h1);
    check_mode(3'h0);
    reg_read(ma + 32'h4, d);
    check_word(d, 32'h0);
    reg_write(ma, 32'h3);
    reg_write(ma, 32'h1);
    check_word({31'h0, seq_err}, 32'h1);
    reg_write(ma, 32'h0);
    check_word({31'h0, seq_err}, 32'h0);
    reg_write(ma, 32'h20);
    // the pulse stands after the write edge, the model counts it next edge
    @(negedge clock);
    check_word({24'h0, flush_count}, 32'h2);
    reg_read(ma, d);
    check_word(d, 32'h0);
    print_verdict();
  end

endmodule : otp_mode_ctrl_tb
